// *** bench/scb_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host that shifts control words over the three-wire pins.
// ****************************************************************
module scb_host_model
(
  input  wire logic clk_sys,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_le
);
  // Pins start low; clock and load idle low and the clock stands still between words.
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end

  // Each pin level is held four system clocks, just after an edge.
  task automatic step;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : step

  // Sends one word most significant bit first, then pulses load.
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      ser_data = w[i];
      step();
      ser_clk = 1'b1;
      step();
      ser_clk = 1'b0;
    end
    step();
    ser_le = 1'b1;
    step();
    ser_le = 1'b0;
    ser_data = ~w[0]; // The data line no longer holds a valid bit.
    step();
  endtask : send
endmodule : scb_host_model
`default_nettype wire

// *** bench/scb_synth_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Output checker for the control register bank.
// ****************************************************************
module scb_synth_ctrl_assertions
  import scb_pkg::*;
#(
  parameter int unsigned TMO_W = RESYNC_CNT_W
)
(
  input wire logic             clk_sys,
  input wire logic             resetn,
  input wire logic [TMO_W-1:0] resync_timeout,
  input wire logic             sd_reset_q,
  input wire logic             resync_pulse_q,
  input wire logic             pfd_ref_q,
  input wire logic             pump_off_q,
  input wire logic             counters_rst_q,
  input wire logic             lock_rst_q,
  input wire logic             outputs_en_q,
  input wire logic             bleed_on_q
);
  // All properties share the system clock and its reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Reset leaves the pump three-stated, no pulses and outputs off.
  a_reset_values: assert property ($rose(resetn) |-> pump_off_q && !sd_reset_q && !resync_pulse_q && !outputs_en_q)
    else $error("reset values wrong");
  a_sd_single: assert property (sd_reset_q |=> !sd_reset_q)
    else $error("modulator reset pulse too long");
  a_resync_single: assert property (resync_pulse_q |=> !resync_pulse_q)
    else $error("resync pulse too long");
  a_resync_waits: assert property (sd_reset_q && resync_timeout != '0 |-> !resync_pulse_q)
    else $error("resync came with the write");
  a_pdown_outputs: assert property (lock_rst_q |-> !outputs_en_q && pump_off_q)
    else $error("power-down left outputs on");
  a_pdown_hold: assert property (lock_rst_q [*3] |=> $stable(pfd_ref_q))
    else $error("reference ran in power-down");
  a_count_hold: assert property (counters_rst_q [*3] |=> $stable(pfd_ref_q))
    else $error("reference ran in counter reset");
  a_bleed_pdown: assert property (lock_rst_q [*2] |-> !bleed_on_q)
    else $error("bleed on in power-down");

  // Main scenarios that the bench must reach.
  c_sd: cover property (sd_reset_q);
  c_resync: cover property (resync_pulse_q);
  c_pdown: cover property (lock_rst_q [*3]);
endmodule : scb_synth_ctrl_assertions

bind scb_synth_ctrl scb_synth_ctrl_assertions #(.TMO_W(TMO_W)) u_scb_chk (
  .clk_sys(clk_sys), .resetn(resetn), .resync_timeout(resync_timeout), .sd_reset_q(sd_reset_q),
  .resync_pulse_q(resync_pulse_q), .pfd_ref_q(pfd_ref_q), .pump_off_q(pump_off_q),
  .counters_rst_q(counters_rst_q), .lock_rst_q(lock_rst_q), .outputs_en_q(outputs_en_q), .bleed_on_q(bleed_on_q));
`default_nettype wire

// *** bench/synth_control_register_bank_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Self-checking bench for the control register bank.
// ****************************************************************
module synth_control_register_bank_bench;
  import scb_pkg::*;
  logic                    clk_sys, resetn, ser_clk, ser_data, ser_le, ref_in, lock_detect, test_n_div;
  logic [RESYNC_CNT_W-1:0] resync_timeout;
  logic [27:0]             aux_modulus_q;
  logic [23:0]             phase_offset_q;
  logic [3:0]              pump_current_q;
  logic [2:0]              out_div_q;
  logic                    sd_reset_q, resync_pulse_q, test_out_q, test_level_q, doubler_q, pfd_ref_q;
  logic                    polarity_q, pump_off_q, counters_rst_q, lock_rst_q, outputs_en_q, bleed_on_q;
  logic [31:0]             exp_q[$];
  logic [31:0]             w;
  logic [23:0]             p;
  logic [13:0]             lo, hi;
  logic [2:0]              d;
  int                      kind_q[$];
  int                      err_count, tests_run, sd_cnt, rs_cnt, sd_t, rs_t, cyc, tmo, s;
  int                      r, rr, pp, pf_cnt, pf0, tm_cnt, tm0;

  scb_host_model u_scb_host_model (.clk_sys(clk_sys), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le));

  scb_synth_ctrl u_scb_synth_ctrl (.clk_sys(clk_sys), .resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_le(ser_le), .ref_in(ref_in), .lock_detect(lock_detect), .resync_timeout(resync_timeout),
    .test_n_div(test_n_div), .aux_modulus_q(aux_modulus_q), .sd_reset_q(sd_reset_q),
    .resync_pulse_q(resync_pulse_q), .phase_offset_q(phase_offset_q), .test_out_q(test_out_q),
    .test_level_q(test_level_q), .doubler_q(doubler_q), .pfd_ref_q(pfd_ref_q), .pump_current_q(pump_current_q),
    .polarity_q(polarity_q), .pump_off_q(pump_off_q), .counters_rst_q(counters_rst_q), .lock_rst_q(lock_rst_q),
    .outputs_en_q(outputs_en_q), .out_div_q(out_div_q), .bleed_on_q(bleed_on_q));

  // Clock, a slow reference and a slow divider signal off the sampling edge.
  always #5 clk_sys = ~clk_sys;
  always #40 ref_in = ~ref_in;
  always #70 test_n_div = ~test_n_div;

  // Counts the pulses and remembers when they came.
  always @(posedge clk_sys)
  begin
    cyc++;
    if (sd_reset_q === 1'b1)
    begin
      sd_cnt++;
      sd_t = cyc;
    end
    if (resync_pulse_q === 1'b1)
    begin
      rs_cnt++;
      rs_t = cyc;
    end
    if (pfd_ref_q === 1'b1)
      pf_cnt++;
    if (test_out_q === 1'b1)
      tm_cnt++;
  end

  // Picks the output group that a note refers to.
  function automatic logic [31:0] probe(int k);
    case (k)
      0: probe = {4'h0, aux_modulus_q};
      1: probe = {8'h00, phase_offset_q};
      2: probe = {21'h0, test_level_q, doubler_q, polarity_q, pump_off_q, counters_rst_q, lock_rst_q,
                  outputs_en_q, pump_current_q};
      3: probe = {29'h0, out_div_q};
      4: probe = {31'h0, bleed_on_q};
      5: probe = {31'h0, test_out_q};
      6: probe = 32'(sd_cnt);
      7: probe = 32'(rs_cnt);
      9: probe = 32'(pf_cnt - pf0);
      10: probe = 32'(tm_cnt - tm0);
      default: probe = {31'h0, 1'((rs_t - sd_t >= tmo) && (rs_t - sd_t <= tmo + 2))};
    endcase
  endfunction : probe

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Notes an expected value for the watching process.
  task automatic expect_v(input logic [31:0] e, input int k);
    exp_q.push_back(e);
    kind_q.push_back(k);
  endtask : expect_v

  task automatic wr(input logic [31:0] x);
    u_scb_host_model.send(x);
    repeat (6) @(posedge clk_sys);
    #1;
  endtask : wr

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // Takes the oldest note whenever one is waiting and compares it.
  initial
  begin
    forever
    begin
      wait (exp_q.size() != 0);
      check(probe(kind_q[0]), exp_q[0]);
      void'(exp_q.pop_front());
      void'(kind_q.pop_front());
    end
  end

  // Cuts a hang short.
  initial
  begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  // Main sequence.
  initial
  begin
    clk_sys = 0; resetn = 0; ref_in = 0; lock_detect = 0; test_n_div = 0; resync_timeout = '0;
    w = $urandom(32'hAD87);
    repeat (19) @(posedge clk_sys);
    #1;
    expect_v(32'h0000_0080, 2);
    @(posedge clk_sys);
    #1 resetn = 1;
    for (int i = 0; i < 6; i++)
    begin
      w = $urandom;
      w[31:28] = 4'h3;
      w[6] = 1'b0;
      w[3:0] = SEL_REF;
      wr(w);
      expect_v({21'h0, w[8], w[26], w[7], w[5], w[4], 2'b01, w[13:10]}, 2);
    end
    wr(32'h3000_0054);
    expect_v(32'h0000_00E0, 2);
    wr(32'h3000_0057);
    expect_v(32'h0000_00E0, 2);
    $display("test reference done");
    lo = 14'($urandom);
    hi = 14'($urandom);
    wr({14'h0, lo, SEL_AUX_LOW});
    wr({14'h0, hi, SEL_AUX_HIGH});
    expect_v({4'h0, hi, lo}, 0);
    $display("test modulus done");
    p = 24'($urandom);
    wr({4'b0101, p, SEL_PHASE});
    expect_v({8'h00, p}, 1);
    s = sd_cnt;
    wr($urandom & 32'h001F_FFF0);
    expect_v({8'h00, 24'(p + p)}, 1);
    expect_v(32'(s), 6);
    wr($urandom & 32'h001F_FFF0);
    expect_v({8'h00, 24'(p + p + p)}, 1);
    $display("test phase step done");
    tmo = 3 + $urandom % 8;
    resync_timeout = 20'(tmo);
    p = 24'($urandom);
    wr({4'b0010, p, SEL_PHASE});
    expect_v({8'h00, p}, 1);
    s = sd_cnt;
    r = rs_cnt;
    wr($urandom & 32'h001F_FFF0);
    // The longest timeout fires after the write task returns, so wait for it.
    repeat (12) @(posedge clk_sys);
    #1;
    expect_v(32'(s + 1), 6);
    expect_v(32'(r + 1), 7);
    expect_v(32'h1, 8);
    wr({4'b0000, p, SEL_PHASE});
    s = rs_cnt;
    wr($urandom & 32'h001F_FFF0);
    repeat (12) @(posedge clk_sys);
    #1;
    expect_v({8'h00, p}, 1);
    expect_v(32'(s), 7);
    $display("test resync done");
    d = 3'(1 + $urandom % 7);
    wr(32'h3000_4004);
    expect_v(32'h0000_0010, 2);
    wr({2'b01, 6'h0, d, 17'h0, SEL_OUTPUT});
    expect_v(32'h0, 3);
    expect_v(32'h0, 4);
    lock_detect = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    expect_v(32'h1, 4);
    wr($urandom & 32'h001F_FFF0);
    expect_v({29'h0, d}, 3);
    $display("test buffer and bleed done");
    wr(32'h0800_0004);
    expect_v(32'h1, 5);
    wr(32'h0000_0004);
    expect_v(32'h0, 5);
    $display("test mux done");
    // The reference toggles every four system clocks, so one edge kind recurs every eight.
    for (int i = 0; i < 3; i++)
    begin
      rr = 1 + $urandom % 3;
      w = {2'b00, 3'h3, 2'($urandom), 10'(rr), 11'h000, SEL_REF};
      pp = (w[26] ? 4 : 8) * rr;
      wr(w);
      repeat (2 * pp) @(posedge clk_sys);
      #1;
      pf0 = pf_cnt;
      tm0 = tm_cnt;
      repeat (10 * pp) @(posedge clk_sys);
      #1;
      expect_v(w[25] ? 32'(5 * pp) : 32'hA, 9);
      expect_v(w[25] ? 32'(5 * pp) : 32'hA, 10);
    end
    $display("test reference divider done");
    wait (exp_q.size() == 0);
    tally_and_finish();
  end
endmodule : synth_control_register_bank_bench
`default_nettype wire

// *** hw/scb_ref_path.sv ***
`timescale 1ns/1ps
`default_nettype none
module scb_ref_path
  import scb_pkg::*;
#(
  parameter int unsigned CNT_W = RCNT_W
)
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ref_tick,
  input  wire logic              hold_rst,
  input  wire logic              halver_en,
  input  wire logic [CNT_W-1:0]  ratio,
  output logic                   pfd_ref_q
);

  // ****************************************************************
  // Reference divider and divide-by-two stage.
  // ****************************************************************
  logic [CNT_W-1:0] cnt_q;
  logic             pulse_q;
  logic             tog_q;

  // Count reference ticks; emit one pulse every ratio ticks (0 acts as 1).
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || hold_rst)
    begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end
    else if (ref_tick)
    begin
      if (cnt_q + CNT_W'(1) >= ratio)
      begin
        cnt_q   <= '0;
        pulse_q <= 1'b1;
      end
      else
      begin
        cnt_q   <= cnt_q + CNT_W'(1);
        pulse_q <= 1'b0;
      end
    end
    else
      pulse_q <= 1'b0;
  end

  // Toggle gives a 50 percent duty reference when enabled.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn || hold_rst)
    begin
      tog_q     <= 1'b0;
      pfd_ref_q <= 1'b0;
    end
    else
    begin
      if (pulse_q)
        tog_q <= ~tog_q;
      pfd_ref_q <= halver_en ? tog_q : pulse_q;
    end
  end

endmodule : scb_ref_path
`default_nettype wire

// *** hw/scb_serial_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module scb_serial_rx
  import scb_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  input  wire logic              ser_clk,
  input  wire logic              ser_data,
  input  wire logic              ser_le,
  output logic [WORD_W-1:0]      word_q,
  output logic                   word_valid_q
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [1:0] clk_s_q;
  logic [1:0] dat_s_q;
  logic [1:0] le_s_q;
  logic       clk_d1_q;
  logic       le_d1_q;
  logic [WORD_W-1:0] shift_q;

  // Two flops per pin; only the second stage is read.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      clk_s_q <= 2'h0;
      dat_s_q <= 2'h0;
      le_s_q  <= 2'h0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[0], ser_clk};
      dat_s_q <= {dat_s_q[0], ser_data};
      le_s_q  <= {le_s_q[0], ser_le};
    end
  end

  // Edge history of the synchronised clock and load enable.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      clk_d1_q <= 1'b0;
      le_d1_q  <= 1'b0;
    end
    else
    begin
      clk_d1_q <= clk_s_q[1];
      le_d1_q  <= le_s_q[1];
    end
  end

  // Shift in MSB first on each rising serial clock.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      shift_q <= RST_WORD;
    else if (clk_s_q[1] && !clk_d1_q)
      shift_q <= {shift_q[WORD_W-2:0], dat_s_q[1]};
  end

  // Present the word for one cycle when load enable rises.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      word_q       <= RST_WORD;
      word_valid_q <= 1'b0;
    end
    else
    begin
      word_valid_q <= le_s_q[1] && !le_d1_q;
      if (le_s_q[1] && !le_d1_q)
        word_q <= shift_q;
    end
  end

endmodule : scb_serial_rx
`default_nettype wire

// *** hw/scb_synth_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module scb_synth_ctrl
  import scb_pkg::*;
#(
  parameter int unsigned TMO_W = RESYNC_CNT_W
)
(
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   ser_clk,
  input  wire logic                   ser_data,
  input  wire logic                   ser_le,
  input  wire logic                   ref_in,
  input  wire logic                   lock_detect,
  input  wire logic [TMO_W-1:0]       resync_timeout,
  input  wire logic                   test_n_div,
  output logic [2*AUX_PART_W-1:0]     aux_modulus_q,
  output logic                        sd_reset_q,
  output logic                        resync_pulse_q,
  output logic [PH_VAL_W-1:0]         phase_offset_q,
  output logic                        test_out_q,
  output logic                        test_level_q,
  output logic                        doubler_q,
  output logic                        pfd_ref_q,
  output logic [CP_W-1:0]             pump_current_q,
  output logic                        polarity_q,
  output logic                        pump_off_q,
  output logic                        counters_rst_q,
  output logic                        lock_rst_q,
  output logic                        outputs_en_q,
  output logic [DIV_W-1:0]            out_div_q,
  output logic                        bleed_on_q
);

  // ****************************************************************
  // Serial receiver and register store.
  // ****************************************************************
  logic [WORD_W-1:0] word;
  logic              word_valid;
  logic [WORD_W-1:0] aux_low_q;
  logic [WORD_W-1:0] aux_high_q;
  logic [WORD_W-1:0] phase_q;
  logic [WORD_W-1:0] ref_q;
  logic [WORD_W-1:0] fixed_q;
  logic [WORD_W-1:0] output_q;
  logic [SEL_W-1:0]  sel;
  logic              freq_wr;
  logic              pfd_ref;

  assign sel     = word[SEL_W-1:0];
  assign freq_wr = word_valid && (sel == SEL_FREQ);

  scb_serial_rx u_rx (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .ser_clk      (ser_clk),
    .ser_data     (ser_data),
    .ser_le       (ser_le),
    .word_q       (word),
    .word_valid_q (word_valid)
  );

  // Route each latched word by its select code; contents survive power-down.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      aux_low_q  <= RST_WORD;
      aux_high_q <= RST_WORD;
      phase_q    <= RST_WORD;
      ref_q      <= RST_WORD;
      fixed_q    <= RST_WORD;
      output_q   <= RST_WORD;
    end
    else if (word_valid)
    begin
      case (sel)
        SEL_AUX_LOW:  aux_low_q  <= word;
        SEL_AUX_HIGH: aux_high_q <= word;
        SEL_PHASE:    phase_q    <= word;
        SEL_REF:      ref_q      <= word;
        SEL_FIXED:    fixed_q    <= word;
        SEL_OUTPUT:   output_q   <= word;
        default:      ;
      endcase
    end
  end

  // ****************************************************************
  // Modulus, sigma-delta reset and phase control.
  // ****************************************************************

  // Auxiliary modulus composed from its two halves.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      aux_modulus_q <= '0;
    else
      aux_modulus_q <= {aux_high_q[AUX_HIGH_LSB +: AUX_PART_W],
                        aux_low_q[AUX_LOW_LSB +: AUX_PART_W]};
  end

  // One-cycle modulator reset per frequency write unless disabled.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      sd_reset_q <= 1'b0;
    else
      sd_reset_q <= freq_wr && !phase_q[PH_SDRST_DIS];
  end

  // Phase offset: fraction of 2^24 of a turn; steps add on each frequency write.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      phase_offset_q <= '0;
    else if (word_valid && sel == SEL_PHASE)
      phase_offset_q <= word[PH_VAL_LSB +: PH_VAL_W];
    else if (freq_wr && phase_q[PH_STEP_EN])
      phase_offset_q <= phase_offset_q + phase_q[PH_VAL_LSB +: PH_VAL_W];
  end

  // Resync timer: armed by a frequency write, fires once when it elapses.
  logic [TMO_W-1:0] tmo_q;
  logic             tmo_run_q;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      tmo_q          <= '0;
      tmo_run_q      <= 1'b0;
      resync_pulse_q <= 1'b0;
    end
    else
    begin
      resync_pulse_q <= 1'b0;
      if (freq_wr && phase_q[PH_RESYNC_EN])
      begin
        tmo_q     <= resync_timeout;
        tmo_run_q <= 1'b1;
      end
      else if (tmo_run_q)
      begin
        if (tmo_q == '0)
        begin
          tmo_run_q      <= 1'b0;
          resync_pulse_q <= phase_q[PH_RESYNC_EN];
        end
        else
          tmo_q <= tmo_q - TMO_W'(1);
      end
    end
  end

  // ****************************************************************
  // Reference path.
  // ****************************************************************
  logic [1:0] ref_s_q;
  logic       ref_d1_q;
  logic       ref_tick;

  // Synchronise the reference and pick active edges.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ref_s_q  <= 2'h0;
      ref_d1_q <= 1'b0;
    end
    else
    begin
      ref_s_q  <= {ref_s_q[0], ref_in};
      ref_d1_q <= ref_s_q[1];
    end
  end

  // Doubler makes both edges count; otherwise only the falling edge.
  assign ref_tick = ref_q[RF_DOUBLER] ? (ref_s_q[1] ^ ref_d1_q)
                                      : (!ref_s_q[1] && ref_d1_q);

  scb_ref_path #(
    .CNT_W (RCNT_W)
  ) u_ref (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .ref_tick  (ref_tick),
    .hold_rst  (ref_q[RF_CNT_RST] || ref_q[RF_PDOWN]),
    .halver_en (ref_q[RF_HALVER]),
    .ratio     (ref_q[RF_RCNT_LSB +: RCNT_W]),
    .pfd_ref_q (pfd_ref)
  );

  // ****************************************************************
  // Pump, power, test pin and output control.
  // ****************************************************************

  // Retimed divided reference and static control outputs decoded from the reference register.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      pfd_ref_q      <= 1'b0;
      doubler_q      <= 1'b0;
      pump_current_q <= '0;
      test_level_q   <= 1'b0;
      polarity_q     <= 1'b0;
      pump_off_q     <= 1'b1;
      counters_rst_q <= 1'b0;
      lock_rst_q     <= 1'b0;
      outputs_en_q   <= 1'b0;
    end
    else
    begin
      pfd_ref_q      <= pfd_ref;
      doubler_q      <= ref_q[RF_DOUBLER];
      pump_current_q <= ref_q[RF_CP_LSB +: CP_W];
      test_level_q   <= ref_q[RF_LEVEL];
      polarity_q     <= ref_q[RF_POLARITY];
      pump_off_q     <= ref_q[RF_TRISTATE] || ref_q[RF_PDOWN];
      counters_rst_q <= ref_q[RF_CNT_RST] || ref_q[RF_PDOWN];
      lock_rst_q     <= ref_q[RF_PDOWN];
      outputs_en_q   <= !ref_q[RF_PDOWN];
    end
  end

  // Test multiplexer: selects among internal signals by a 3-bit code.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      test_out_q <= 1'b0;
    else
    begin
      case (ref_q[RF_MUX_LSB +: RF_MUX_W])
        3'h0:    test_out_q <= 1'b0;
        3'h1:    test_out_q <= 1'b1;
        3'h2:    test_out_q <= 1'b0;
        3'h3:    test_out_q <= pfd_ref;
        3'h4:    test_out_q <= test_n_div;
        3'h6:    test_out_q <= lock_detect;
        default: test_out_q <= 1'b0;
      endcase
    end
  end

  // Divider select, optionally held until the next frequency write.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      out_div_q <= '0;
    else if (!ref_q[RF_DBUF] || freq_wr)
      out_div_q <= output_q[OUT_DIV_LSB +: DIV_W];
  end

  // Bleed stays off until lock when gated.
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      bleed_on_q <= 1'b0;
    else
      bleed_on_q <= !ref_q[RF_PDOWN] && (!output_q[OUT_GBLEED] || lock_detect);
  end

endmodule : scb_synth_ctrl
`default_nettype wire

// *** include/scb_pkg.sv ***
package scb_pkg;

  // ****************************************************************
  // Serial word layout.
  // ****************************************************************
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned SEL_W         = 4;
  localparam logic [3:0]  SEL_FREQ      = 4'h0;
  localparam logic [3:0]  SEL_AUX_LOW   = 4'h2;
  localparam logic [3:0]  SEL_PHASE     = 4'h3;
  localparam logic [3:0]  SEL_REF       = 4'h4;
  localparam logic [3:0]  SEL_FIXED     = 4'h5;
  localparam logic [3:0]  SEL_OUTPUT    = 4'h6;
  localparam logic [3:0]  SEL_AUX_HIGH  = 4'hD;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int unsigned AUX_PART_W    = 14;
  localparam int unsigned AUX_LOW_LSB   = 4;
  localparam int unsigned AUX_HIGH_LSB  = 4;
  localparam int unsigned PH_SDRST_DIS  = 30;
  localparam int unsigned PH_RESYNC_EN  = 29;
  localparam int unsigned PH_STEP_EN    = 28;
  localparam int unsigned PH_VAL_LSB    = 4;
  localparam int unsigned PH_VAL_W      = 24;
  localparam int unsigned RF_MUX_LSB    = 27;
  localparam int unsigned RF_MUX_W      = 3;
  localparam int unsigned RF_DOUBLER    = 26;
  localparam int unsigned RF_HALVER     = 25;
  localparam int unsigned RF_RCNT_LSB   = 15;
  localparam int unsigned RCNT_W        = 10;
  localparam int unsigned RF_DBUF       = 14;
  localparam int unsigned RF_CP_LSB     = 10;
  localparam int unsigned CP_W          = 4;
  localparam int unsigned RF_LEVEL      = 8;
  localparam int unsigned RF_POLARITY   = 7;
  localparam int unsigned RF_PDOWN      = 6;
  localparam int unsigned RF_TRISTATE   = 5;
  localparam int unsigned RF_CNT_RST    = 4;
  localparam int unsigned OUT_GBLEED    = 30;
  localparam int unsigned OUT_DIV_LSB   = 21;
  localparam int unsigned DIV_W         = 3;
  localparam int unsigned RESYNC_CNT_W  = 20;

  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [9:0]  RST_RCOUNT    = 10'h001;

endpackage : scb_pkg
